/* inc/io_pins_pkg.sv */
// Purpose: Shared constants and types for the rear-panel status and trigger pin block.
// Assumes: Index 0 is the on/off status pin and index 1 is the trigger pin.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
package io_pins_pkg;

    // Clock rate and the least low time of a trigger pulse.
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned TRIG_MIN_LOW_NS = 30000;
    localparam int unsigned TRIG_MIN_LOW_CYCLES = (TRIG_MIN_LOW_NS * CLOCK_MHZ + 999) / 1000;

    // Counter and address widths.
    localparam int unsigned CNT_W = 16;
    localparam int unsigned ADDR_W = 8;

    // Register byte offsets.
    localparam logic [7:0] ADDR_STATUS_CFG = 8'h00;
    localparam logic [7:0] ADDR_TRIG_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS_PWM = 8'h08;
    localparam logic [7:0] ADDR_TRIG_PWM = 8'h0c;
    localparam logic [7:0] ADDR_PIN_STATE = 8'h10;
    localparam logic [7:0] ADDR_EVENTS = 8'h14;

    // Event bit positions in the sticky event register.
    localparam int unsigned EV_TRIG_IN = 0;
    localparam int unsigned EV_TRIG_OUT = 1;

    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin modes: the pin's own function, level input, static level output, PWM output.
    typedef enum logic [2:0] {
        MODE_FUNC = 3'h0,
        MODE_IN = 3'h1,
        MODE_OUT = 3'h3,
        MODE_PWM = 3'h2
    } pin_mode_e;

    // What an accepted external trigger starts.
    typedef enum logic [1:0] {
        TGT_METER = 2'h0,
        TGT_DLOG = 2'h1,
        TGT_SEQ = 2'h2
    } trig_target_e;

    // Configuration word of one pin, bits 8..0 of its register.
    typedef struct packed {
        logic sequenceTriggerSourceExt;
        trig_target_e target;
        logic trigIn;
        logic outValue;
        logic invert;
        pin_mode_e mode;
    } pin_cfg_s;

    // PWM word: duty in the upper half, period in the lower half.
    typedef struct packed {
        logic [15:0] duty;
        logic [15:0] period;
    } pwm_cfg_s;

    localparam pin_cfg_s CFG_RESET = '0;
    localparam pwm_cfg_s PWM_RESET = '0;

endpackage : io_pins_pkg

/* src/status_and_trigger_io_pins.sv */
// Purpose: Rear-panel logic for the on/off status pin and the trigger pin, with AXI4-Lite access.
// Assumes: Internal trigger and load state inputs are synchronous to clock.
// Notes: Pin inputs pass two flip-flops; all outputs come from flip-flops.
//
// How it works
// - Status pin default: high while load input off, low while on.
// - Inverted status pin drives the opposite level in every state.
// - Each pin has an invert setting, default normal, for both directions; input mode shows the pin level uninverted.
// - Static output true is low pin normally, high when inverted.
// - Static output false is high pin normally, low when inverted.
// - Input mode samples the pin level and shows it in a register.
// - Trigger-out mode emits one pulse per internal start trigger; a trigger arriving during a pulse gives no pulse of its own.
// - Trigger-in pulse starts at most one configured target function.
// - Trigger pulses hold the low level at least 30 us.
// - External pulse starts the sequence only with external trigger source.
// - Manual source: front-panel sequence trigger also emits an output pulse.
// - After reset both pins use their own function with normal polarity.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module status_and_trigger_io_pins #(
    parameter int unsigned MIN_LOW_CYCLES = io_pins_pkg::TRIG_MIN_LOW_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // AXI4-Lite write address and data.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read.
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Instrument state and internal triggers.
    input wire logic loadOn,
    input wire logic meterTrig,
    input wire logic dlogTrig,
    input wire logic seqTrig,
    input wire logic panelTrig,
    input wire logic acqArmed,
    // Starts caused by an accepted external trigger.
    output logic startMeter,
    output logic startDlog,
    output logic startSeq,
    // Pins: index 0 status, index 1 trigger; enable low while driving.
    input wire logic [1:0] pinIn,
    output logic [1:0] pinOut,
    output logic [1:0] pinOe_n
);

    localparam int unsigned CW = io_pins_pkg::CNT_W;
    localparam logic [CW-1:0] LAST_CNT = CW'(MIN_LOW_CYCLES - 1);

    if (MIN_LOW_CYCLES < 2 || MIN_LOW_CYCLES > 65535) begin : g_bad_width
        $error("MIN_LOW_CYCLES must lie between 2 and 65535");
    end

    io_pins_pkg::pin_cfg_s cfg [2];
    io_pins_pkg::pwm_cfg_s pwm [2];
    logic [1:0] events;
    logic [1:0] pinSync1;
    logic [1:0] pinSync2;
    logic [1:0] funcLvl;
    logic [1:0] funcDrive;
    logic pulseActive;
    logic [CW-1:0] pulseCnt;
    logic [CW-1:0] lowCnt;
    logic [7:0] awAddrHeld;
    logic [31:0] wDataHeld;
    logic [3:0] wStrbHeld;
    logic doWrite;
    logic wrHit;
    logic [31:0] readWord;
    logic readOk;
    logic trigOutMode;
    logic trigInMode;
    logic trigActive;
    logic trigReq;
    logic fire;
    logic [31:0] next_word;

    // Byte-lane merge of a write into an old word.
    function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction : mergeStrb

    // Write channel: address and data are taken in either order, the response follows both.
    assign doWrite = !awready && !wready && !bvalid;
    assign next_word = mergeStrb(32'(cfg[awAddrHeld[2]]), wDataHeld, wStrbHeld);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= io_pins_pkg::RESP_OKAY;
            awAddrHeld <= 8'h00;
            wDataHeld <= 32'h0000_0000;
            wStrbHeld <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                awAddrHeld <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wDataHeld <= wdata;
                wStrbHeld <= wstrb;
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                bresp <= wrHit ? io_pins_pkg::RESP_OKAY : io_pins_pkg::RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_comb begin
        unique case (awAddrHeld)
            io_pins_pkg::ADDR_STATUS_CFG, io_pins_pkg::ADDR_TRIG_CFG,
            io_pins_pkg::ADDR_STATUS_PWM, io_pins_pkg::ADDR_TRIG_PWM,
            io_pins_pkg::ADDR_PIN_STATE, io_pins_pkg::ADDR_EVENTS: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // Configuration registers; reset leaves both pins on their own function, normal polarity.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg[0] <= io_pins_pkg::CFG_RESET;
            cfg[1] <= io_pins_pkg::CFG_RESET;
            pwm[0] <= io_pins_pkg::PWM_RESET;
            pwm[1] <= io_pins_pkg::PWM_RESET;
        end else if (doWrite) begin
            unique case (awAddrHeld)
                io_pins_pkg::ADDR_STATUS_CFG: begin
                    cfg[0] <= io_pins_pkg::pin_cfg_s'(next_word[8:0]);
                end
                io_pins_pkg::ADDR_TRIG_CFG: begin
                    cfg[1] <= io_pins_pkg::pin_cfg_s'(next_word[8:0]);
                end
                io_pins_pkg::ADDR_STATUS_PWM: begin
                    pwm[0] <= mergeStrb(pwm[0], wDataHeld, wStrbHeld);
                end
                io_pins_pkg::ADDR_TRIG_PWM: begin
                    pwm[1] <= mergeStrb(pwm[1], wDataHeld, wStrbHeld);
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky events; a new event in the cycle of its clear wins over the clear.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            events <= 2'h0;
        end else begin
            events <= (events & ~((doWrite && awAddrHeld == io_pins_pkg::ADDR_EVENTS
                                   && wStrbHeld[0]) ? wDataHeld[1:0] : 2'h0))
                      | {trigOutMode && trigReq && !pulseActive, fire};
        end
    end

    // Read channel: one cycle from address to data.
    always_comb begin
        readOk = 1'b1;
        unique case (araddr)
            io_pins_pkg::ADDR_STATUS_CFG: readWord = 32'(cfg[0]);
            io_pins_pkg::ADDR_TRIG_CFG: readWord = 32'(cfg[1]);
            io_pins_pkg::ADDR_STATUS_PWM: readWord = pwm[0];
            io_pins_pkg::ADDR_TRIG_PWM: readWord = pwm[1];
            io_pins_pkg::ADDR_PIN_STATE: readWord = {28'h0, pulseActive, loadOn, pinSync2};
            io_pins_pkg::ADDR_EVENTS: readWord = {30'h0, events};
            default: begin
                readWord = 32'h0000_0000;
                readOk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= io_pins_pkg::RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= readWord;
                rresp <= readOk ? io_pins_pkg::RESP_OKAY : io_pins_pkg::RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Trigger output pulse: a trigger during a pulse is absorbed, so pulses never merge.
    assign trigOutMode = cfg[1].mode == io_pins_pkg::MODE_FUNC && !cfg[1].trigIn;
    assign trigReq = meterTrig || dlogTrig || seqTrig
                     || (panelTrig && !cfg[1].sequenceTriggerSourceExt);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pulseActive <= 1'b0;
            pulseCnt <= '0;
        end else if (!pulseActive) begin
            pulseCnt <= '0;
            pulseActive <= trigOutMode && trigReq;
        end else begin
            pulseCnt <= pulseCnt + 1'b1;
            pulseActive <= pulseCnt != LAST_CNT;
        end
    end

    // Trigger input qualification: the active level must persist for the full least width.
    assign trigInMode = cfg[1].mode == io_pins_pkg::MODE_FUNC && cfg[1].trigIn;
    assign trigActive = pinSync2[1] == cfg[1].invert;
    assign fire = trigInMode && trigActive && lowCnt == LAST_CNT;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lowCnt <= '0;
        end else if (!(trigInMode && trigActive)) begin
            lowCnt <= '0;
        end else if (lowCnt != CW'(MIN_LOW_CYCLES)) begin
            lowCnt <= lowCnt + 1'b1;
        end
    end

    // One start per accepted pulse, gated by arming and the sequence trigger source.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            startMeter <= 1'b0;
            startDlog <= 1'b0;
            startSeq <= 1'b0;
        end else begin
            startMeter <= fire && cfg[1].target == io_pins_pkg::TGT_METER && acqArmed;
            startDlog <= fire && cfg[1].target == io_pins_pkg::TGT_DLOG;
            startSeq <= fire && cfg[1].target == io_pins_pkg::TGT_SEQ
                        && cfg[1].sequenceTriggerSourceExt;
        end
    end

    // Own-function logical levels: a logical 1 is a low pin under normal polarity.
    assign funcLvl[0] = loadOn;
    assign funcLvl[1] = pulseActive;
    assign funcDrive[0] = 1'b1;
    assign funcDrive[1] = !cfg[1].trigIn;

    for (genvar i = 0; i < 2; i++) begin : g_pin
        logic [15:0] pwmCnt;
        logic lvl;
        logic drive;

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                pinSync1[i] <= 1'b1;
                pinSync2[i] <= 1'b1;
            end else begin
                pinSync1[i] <= pinIn[i];
                pinSync2[i] <= pinSync1[i];
            end
        end

        // A period of zero holds the counter, so the PWM level follows duty alone.
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                pwmCnt <= 16'h0000;
            end else if (pwmCnt >= pwm[i].period - 16'h0001 || pwm[i].period == 16'h0000) begin
                pwmCnt <= 16'h0000;
            end else begin
                pwmCnt <= pwmCnt + 16'h0001;
            end
        end

        always_comb begin
            unique case (cfg[i].mode)
                io_pins_pkg::MODE_FUNC: begin
                    lvl = funcLvl[i];
                    drive = funcDrive[i];
                end
                io_pins_pkg::MODE_IN: begin
                    lvl = 1'b0;
                    drive = 1'b0;
                end
                io_pins_pkg::MODE_OUT: begin
                    lvl = cfg[i].outValue;
                    drive = 1'b1;
                end
                default: begin
                    lvl = pwmCnt < pwm[i].duty;
                    drive = 1'b1;
                end
            endcase
        end

        always_ff @(posedge clock) begin
            if (!rst_n) begin
                pinOut[i] <= 1'b1;
                pinOe_n[i] <= 1'b1;
            end else begin
                pinOut[i] <= !lvl ^ cfg[i].invert;
                pinOe_n[i] <= !drive;
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_status_normal;
        $past(rst_n) && $past(cfg[0].mode == io_pins_pkg::MODE_FUNC && !cfg[0].invert)
        |-> pinOut[0] == !$past(loadOn) && !pinOe_n[0];
    endproperty
    a_status_normal: assert property (p_status_normal) else $error("status pin level wrong");

    property p_status_invert;
        $past(rst_n) && $past(cfg[0].mode == io_pins_pkg::MODE_FUNC && cfg[0].invert)
        |-> pinOut[0] == $past(loadOn);
    endproperty
    a_status_invert: assert property (p_status_invert) else $error("inverted status wrong");

    property p_out_true;
        $past(rst_n) && $past(cfg[0].mode == io_pins_pkg::MODE_OUT && cfg[0].outValue)
        |-> pinOut[0] == $past(cfg[0].invert);
    endproperty
    a_out_true: assert property (p_out_true) else $error("static true level wrong");

    property p_out_false;
        $past(rst_n) && $past(cfg[0].mode == io_pins_pkg::MODE_OUT && !cfg[0].outValue)
        |-> pinOut[0] == !$past(cfg[0].invert);
    endproperty
    a_out_false: assert property (p_out_false) else $error("static false level wrong");

    property p_input_sync;
        $past(rst_n, 2) |-> pinSync2 == $past(pinIn, 2);
    endproperty
    a_input_sync: assert property (p_input_sync) else $error("input sample not two cycles");

    property p_trig_out;
        trigOutMode && trigReq && !pulseActive |=> pulseActive ##1 pinOut[1] == cfg[1].invert;
    endproperty
    a_trig_out: assert property (p_trig_out) else $error("trigger request gave no pulse");

    property p_pulse_width;
        $fell(pulseActive) |-> $past(pulseCnt) == LAST_CNT;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("pulse ended early");

    property p_one_target;
        $onehot0({startMeter, startDlog, startSeq});
    endproperty
    a_one_target: assert property (p_one_target) else $error("more than one start");

    property p_seq_source;
        startSeq |-> $past(cfg[1].sequenceTriggerSourceExt);
    endproperty
    a_seq_source: assert property (p_seq_source) else $error("sequence start without source");

    property p_panel;
        panelTrig && !cfg[1].sequenceTriggerSourceExt && trigOutMode && !pulseActive
        |=> pulseActive;
    endproperty
    a_panel: assert property (p_panel) else $error("panel trigger gave no pulse");

    property p_defaults;
        $past(!rst_n) |-> cfg[0] == io_pins_pkg::CFG_RESET && cfg[1] == io_pins_pkg::CFG_RESET;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not applied");

    property p_qualified;
        startMeter || startDlog || startSeq |-> $past(lowCnt) == LAST_CNT && $past(trigActive);
    endproperty
    a_qualified: assert property (p_qualified) else $error("start without qualified pulse");

    property p_pwm_zero;
        $past(rst_n) && $past(cfg[1].mode == io_pins_pkg::MODE_PWM && pwm[1].duty == 16'h0000)
        |-> pinOut[1] == !$past(cfg[1].invert);
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) else $error("zero duty PWM not idle");

endmodule : status_and_trigger_io_pins

/* verification/io_pins_partner.sv */
// Purpose: Far-side instrument model on the status and trigger pins.
// Assumes: Both pins are pulled high by the instrument while nobody drives them.
// Notes: Measures the low length of every pulse that the block drives on the trigger pin.
`timescale 1ns/1ps
module io_pins_partner (
    // Clock.
    input wire logic clock,
    // Pins as the block drives them.
    input wire logic [1:0] pinOut,
    input wire logic [1:0] pinOe_n,
    // Pin levels back to the block.
    output logic [1:0] pinIn
);
    logic [1:0] extLevel = 2'h3;
    int runLen = 0;
    int lastLen = 0;
    int pulses = 0;

    // A driven pin shows the block's level, a released one shows ours.
    assign pinIn[0] = pinOe_n[0] ? extLevel[0] : pinOut[0];
    assign pinIn[1] = pinOe_n[1] ? extLevel[1] : pinOut[1];

    always @(posedge clock) begin
        if (pinOe_n[1] === 1'h0 && pinOut[1] === 1'h0) begin
            runLen <= runLen + 1;
        end else begin
            if (runLen != 0) begin
                lastLen <= runLen;
                pulses <= pulses + 1;
            end
            runLen <= 0;
        end
    end

    task automatic setLevel(input int idx, input logic val);
        @(posedge clock);
        extLevel[idx] <= val;
    endtask : setLevel

    // Holds the active level for the given cycles, then goes back to idle.
    task automatic sendPulse(input int width, input logic act);
        @(posedge clock);
        extLevel[1] <= act;
        repeat (width) @(posedge clock);
        extLevel[1] <= !act;
    endtask : sendPulse
endmodule : io_pins_partner

/* verification/status_and_trigger_io_pins_tb_top.sv */
// Purpose: Self-checking bench for the status and trigger pin block.
// Assumes: A short minimum pulse width keeps the run brief.
// Notes: Expected levels are worked out from the pin rules, never read back from the block.
`timescale 1ns/1ps
module status_and_trigger_io_pins_tb_top;
    localparam int MINL = 8;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf, trg = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic loadOn = 1'h0, acqArmed = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, startMeter, startDlog, startSeq;
    logic [1:0] bresp, rresp, pinIn, pinOut, pinOe_n;
    logic [31:0] rdata;
    int seed = 32'hea21;
    int nMismatch = 0, checked = 0, nMeter = 0, nDlog = 0, nSeq = 0;

    initial forever #2 clock = !clock;

    status_and_trigger_io_pins #(.MIN_LOW_CYCLES(MINL)) status_and_trigger_io_pins_inst (
        .clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .loadOn, .meterTrig(trg[0]), .dlogTrig(trg[1]), .seqTrig(trg[2]),
        .panelTrig(trg[3]), .acqArmed, .startMeter, .startDlog, .startSeq, .pinIn, .pinOut,
        .pinOe_n);

    io_pins_partner io_partner_inst (.clock(clock), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .pinIn(pinIn));

    always @(posedge clock) begin
        nMeter <= nMeter + (startMeter === 1'h1);
        nDlog <= nDlog + (startDlog === 1'h1);
        nSeq <= nSeq + (startSeq === 1'h1);
    end

    task automatic reportAndStop();
        if (nMismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : reportAndStop

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %0t %s got %h expected %h", $time, msg, got, exp);
            nMismatch++;
        end
    endtask : cmp

    task automatic hang(input string msg);
        $display("[ERR] %0t %s did not answer", $time, msg);
        nMismatch++;
        reportAndStop();
    endtask : hang

    // Logical value to pin level: logic 1 is a low pin unless inverted.
    function automatic logic pinLvl(input logic v, input logic inv);
        return !v ^ inv;
    endfunction : pinLvl

    function automatic logic [1:0] expResp(input logic [7:0] a);
        return (a > io_pins_pkg::ADDR_EVENTS) ? io_pins_pkg::RESP_SLVERR : io_pins_pkg::RESP_OKAY;
    endfunction : expResp

    function automatic logic [31:0] mkCfg(input io_pins_pkg::pin_mode_e m, input logic inv,
        input logic ov, input logic tin, input int t, input logic ext);
        io_pins_pkg::pin_cfg_s c;
        c = '{ext, io_pins_pkg::trig_target_e'(t[1:0]), tin, ov, inv, m};
        return {23'h0, c};
    endfunction : mkCfg

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clock);
            if (awvalid && awready === 1'h1) awvalid <= 1'h0;
            if (wvalid && wready === 1'h1) wvalid <= 1'h0;
            if (bvalid === 1'h1) begin
                cmp(bresp, expResp(a), "write response");
                bready <= 1'h0;
                return;
            end
        end
        hang("write");
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clock);
            if (arvalid && arready === 1'h1) arvalid <= 1'h0;
            if (rvalid === 1'h1) begin
                d = rdata;
                cmp(rresp, expResp(a), "read response");
                rready <= 1'h0;
                return;
            end
        end
        hang("read");
    endtask : axiRead

    // One accepted pulse starts only its target; the meter only when armed, the sequence only when sourced externally.
    function automatic logic accepts(input int t, input logic arm, input logic ext, input int w);
        return w >= MINL && (t != 0 || arm) && (t != 2 || ext);
    endfunction : accepts

    initial begin
        int i, j, p0, w, m0, d0, s0;
        logic [31:0] d;
        static int tgtA[7] = '{0, 0, 1, 2, 2, 1, 1};
        static logic [6:0] armA = 7'h7d, extA = 7'h08, shortA = 7'h20, invA = 7'h40;
        repeat (10) @(posedge clock);
        cmp(pinOe_n, 2'h3, "pins released in reset");
        rst_n <= 1'h1;
        axiRead(io_pins_pkg::ADDR_STATUS_CFG, d);
        cmp(d, 32'h0, "status config default");
        axiRead(io_pins_pkg::ADDR_TRIG_CFG, d);
        cmp(d, 32'h0, "trigger config default");
        axiRead(8'h18, d);
        cmp(d, 32'h0, "unmapped read");
        axiWrite(8'h18, 32'h1);
        for (j = 0; j < 2; j++) begin
            axiWrite(io_pins_pkg::ADDR_STATUS_CFG, mkCfg(io_pins_pkg::MODE_FUNC, j[0], 0, 0, 0, 0));
            for (i = 0; i < 6; i++) begin
                @(posedge clock);
                loadOn <= 1'($random(seed));
                repeat (3) @(posedge clock);
                cmp(pinOut[0], pinLvl(loadOn, j[0]), "status level");
                cmp(pinOe_n[0], 1'h0, "status pin driven");
            end
        end
        for (i = 0; i < 4; i++) begin
            axiWrite(io_pins_pkg::ADDR_STATUS_CFG, mkCfg(io_pins_pkg::MODE_OUT, i[0], i[1], 0, 0, 0));
            repeat (2) @(posedge clock);
            cmp(pinOut[0], pinLvl(i[1], i[0]), "static level");
        end
        axiWrite(io_pins_pkg::ADDR_STATUS_CFG, mkCfg(io_pins_pkg::MODE_IN, 0, 0, 0, 0, 0));
        for (i = 0; i < 4; i++) begin
            p0 = $random(seed);
            io_partner_inst.setLevel(0, p0[0]);
            repeat (4) @(posedge clock);
            axiRead(io_pins_pkg::ADDR_PIN_STATE, d);
            cmp(d[0], p0[0], "input level");
            cmp(pinOe_n[0], 1'h1, "input pin released");
        end
        p0 = {$random(seed)} % 9 + 1;
        axiWrite(io_pins_pkg::ADDR_STATUS_PWM, {16'(p0), 16'h000a});
        axiWrite(io_pins_pkg::ADDR_STATUS_CFG, mkCfg(io_pins_pkg::MODE_PWM, 0, 0, 0, 0, 0));
        repeat (12) @(posedge clock);
        j = 0;
        repeat (10) begin
            @(posedge clock);
            if (pinOut[0] === 1'h0) j++;
        end
        cmp(j, p0, "pwm low cycles per period");
        axiWrite(io_pins_pkg::ADDR_TRIG_PWM, 32'h0000_000a);
        axiWrite(io_pins_pkg::ADDR_TRIG_CFG, mkCfg(io_pins_pkg::MODE_PWM, 0, 0, 0, 0, 0));
        repeat (3) @(posedge clock);
        cmp(pinOut[1], 1'h1, "zero duty pwm level");
        axiWrite(io_pins_pkg::ADDR_TRIG_CFG, 32'h0);
        for (i = 0; i < 5; i++) begin
            if (i == 4) axiWrite(io_pins_pkg::ADDR_TRIG_CFG, mkCfg(io_pins_pkg::MODE_FUNC, 0, 0, 0, 0, 1));
            p0 = io_partner_inst.pulses;
            @(posedge clock);
            trg[(i == 4) ? 3 : i] <= 1'h1;
            @(posedge clock);
            trg[(i == 4) ? 3 : i] <= 1'h0;
            repeat (3) @(posedge clock);
            trg[2] <= (i == 0);
            @(posedge clock);
            trg[2] <= 1'h0;
            repeat (MINL + 6) @(posedge clock);
            cmp(io_partner_inst.pulses - p0, (i < 4), "output pulse count");
            if (i < 4) cmp(io_partner_inst.lastLen, MINL, "output pulse width");
        end
        for (i = 0; i < 7; i++) begin
            w = shortA[i] ? MINL - 1 : (i == 2 ? 3 * MINL : MINL);
            acqArmed <= armA[i];
            axiWrite(io_pins_pkg::ADDR_TRIG_CFG, mkCfg(io_pins_pkg::MODE_FUNC, invA[i], 0, 0, 0, 0));
            io_partner_inst.setLevel(1, !invA[i]);
            axiWrite(io_pins_pkg::ADDR_TRIG_CFG,
                mkCfg(io_pins_pkg::MODE_FUNC, invA[i], 0, 1, tgtA[i], extA[i]));
            m0 = nMeter;
            d0 = nDlog;
            s0 = nSeq;
            io_partner_inst.sendPulse(w, invA[i]);
            repeat (MINL + 8) @(posedge clock);
            p0 = accepts(tgtA[i], armA[i], extA[i], w);
            cmp(nMeter - m0, p0 && tgtA[i] == 0, "meter starts");
            cmp(nDlog - d0, p0 && tgtA[i] == 1, "log starts");
            cmp(nSeq - s0, p0 && tgtA[i] == 2, "sequence starts");
        end
        axiRead(io_pins_pkg::ADDR_EVENTS, d);
        cmp(d[1:0], 2'h3, "events seen");
        axiWrite(io_pins_pkg::ADDR_EVENTS, 32'h3);
        axiRead(io_pins_pkg::ADDR_EVENTS, d);
        cmp(d[1:0], 2'h0, "events cleared");
        reportAndStop();
    end

    // Cuts a hang short well inside the cycle budget.
    initial begin
        repeat (60000) @(posedge clock);
        hang("bench");
    end
endmodule : status_and_trigger_io_pins_tb_top
